// File: rtl/pmbp_programmer.sv
`timescale 1ns/1ns
`include "pmbp_params.svh"

// Operation
// - The strobe pattern sets the sub-mode: write, verify, else inhibit.
// - No page programming: only one byte is handled per pulse sequence.
// - Bytes are written one per programming cycle, high-speed style.
// - Only addresses from the lowest to the last valid one are written.
// - After the procedure every unused location reads as all ones.
// - The overwrite pulse stays between its least and longest width.
// - Above the valid range up to the space top the data is all ones.
module pmbp_programmer
    import pmbp_pkg::*;
#(
    parameter int MAX_TRIES = `PMBP_MAX_TRIES,
    parameter int OVERWRITE_MAX_CYC = `PMBP_OVERWRITE_MAX_CYC,
    parameter int PULSE_CYC = `PMBP_PULSE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid_i,
    input wire logic [16:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic fail_o,
    output logic range_err_o,
    output logic [7:0] read_data_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic program_strobe_n_o,
    output logic [16:0] prom_address_bus_o,
    output logic [7:0] prom_data_bus_o,
    output logic prom_data_bus_oe_o,
    input wire logic [7:0] prom_data_bus_i
);
    localparam int TW = 20;

    pmbp_tmr_if #(.WIDTH(TW)) tmr_bus ();

    pmbp_timer #(.WIDTH(TW)) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .tmr(tmr_bus.tmr)
    );

    pmbp_state_t state_reg, state_next;
    pmbp_sub_t sub_reg, sub_next;
    logic [16:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] tries_reg;
    logic [7:0] sync1_reg, sync2_reg;
    logic [TW-1:0] ov_len_reg;
    logic match;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // overwrite width grows with the tries used, clamped to its window
    function automatic logic [TW-1:0] ov_width(input logic [7:0] tries);
        int w;
        w = `PMBP_OVERWRITE_FACTOR * int'(tries) * PULSE_CYC;
        if (w < `PMBP_OVERWRITE_MIN_CYC)
            w = `PMBP_OVERWRITE_MIN_CYC;
        if (w > OVERWRITE_MAX_CYC)
            w = OVERWRITE_MAX_CYC;
        return TW'(w);
    endfunction

    // blank bytes and addresses past the last valid one stay all ones
    function automatic logic is_blank(input logic [16:0] a,
                                      input logic [7:0] d);
        return (a > `PMBP_ADDR_LAST) || (d == `PMBP_BLANK_BYTE);
    endfunction

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end
        else
        begin
            sync1_reg <= prom_data_bus_i;
            sync2_reg <= sync1_reg;
        end
    end

    assign match = (sync2_reg == data_reg);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        sub_next = sub_reg;
        tmr_bus.load = 1'b0;
        tmr_bus.len = TW'(1);
        unique case (state_reg)
            PMBP_IDLE:
            begin
                sub_next = PMBP_SUB_INHIBIT;
                if (cmd_valid_i && cmd_addr_i <= `PMBP_ADDR_LAST)
                begin
                    state_next = PMBP_SETUP;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = TW'(`PMBP_SETUP_CYC);
                end
            end
            PMBP_SETUP:
                if (tmr_bus.expired)
                begin
                    // all-ones bytes need no pulse, only a verify
                    if (is_blank(addr_reg, data_reg))
                    begin
                        state_next = PMBP_OE_SETUP;
                        tmr_bus.len = TW'(`PMBP_SETUP_CYC);
                    end
                    else
                    begin
                        state_next = PMBP_PULSE;
                        sub_next = PMBP_SUB_WRITE;
                        tmr_bus.len = TW'(PULSE_CYC);
                    end
                    tmr_bus.load = 1'b1;
                end
            PMBP_PULSE:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_HOLD;
                    sub_next = PMBP_SUB_INHIBIT;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = TW'(`PMBP_HOLD_CYC);
                end
            PMBP_HOLD:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_OE_SETUP;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = TW'(`PMBP_SETUP_CYC);
                end
            PMBP_OE_SETUP:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_READ;
                    sub_next = PMBP_SUB_VERIFY;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = TW'(`PMBP_READ_CYC);
                end
            PMBP_READ:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_CHECK;
                    sub_next = PMBP_SUB_INHIBIT;
                end
            PMBP_CHECK:
            begin
                tmr_bus.load = 1'b1;
                tmr_bus.len = TW'(`PMBP_SETUP_CYC);
                if (match && is_blank(addr_reg, data_reg))
                    state_next = PMBP_IDLE;
                else if (match)
                    state_next = PMBP_OV_SETUP;
                else if (int'(tries_reg) >= MAX_TRIES
                         || is_blank(addr_reg, data_reg))
                    state_next = PMBP_IDLE;
                else
                    state_next = PMBP_SETUP;
            end
            PMBP_OV_SETUP:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_OV_PULSE;
                    sub_next = PMBP_SUB_WRITE;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = ov_len_reg;
                end
            PMBP_OV_PULSE:
                if (tmr_bus.expired)
                begin
                    state_next = PMBP_OV_HOLD;
                    sub_next = PMBP_SUB_INHIBIT;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len = TW'(`PMBP_HOLD_CYC);
                end
            PMBP_OV_HOLD:
                if (tmr_bus.expired)
                    state_next = PMBP_IDLE;
            default:
            begin
                state_next = PMBP_IDLE;
                sub_next = PMBP_SUB_INHIBIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= PMBP_IDLE;
            sub_reg <= PMBP_SUB_INHIBIT;
        end
        else
        begin
            state_reg <= state_next;
            sub_reg <= sub_next;
        end
    end

    // ----------------------------------------
    // byte context
    // ----------------------------------------
    // one address and one byte latched per command, never a page
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            addr_reg <= `PMBP_ADDR_LOW;
            data_reg <= `PMBP_BLANK_BYTE;
            tries_reg <= 8'h00;
            ov_len_reg <= TW'(1);
        end
        else if (state_reg == PMBP_IDLE && state_next == PMBP_SETUP)
        begin
            addr_reg <= cmd_addr_i;
            data_reg <= cmd_data_i;
            tries_reg <= 8'h00;
        end
        else if (state_reg == PMBP_SETUP && state_next != PMBP_SETUP)
            tries_reg <= tries_reg + 8'h01;
        else if (state_reg == PMBP_CHECK)
            ov_len_reg <= ov_width(tries_reg);
    end

    // ----------------------------------------
    // results
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            done_o <= 1'b0;
            fail_o <= 1'b0;
            range_err_o <= 1'b0;
            read_data_o <= 8'h00;
        end
        else
        begin
            done_o <= (state_reg == PMBP_OV_HOLD && state_next == PMBP_IDLE)
                      || (state_reg == PMBP_CHECK && match
                          && is_blank(addr_reg, data_reg));
            fail_o <= state_reg == PMBP_CHECK && !match
                      && state_next == PMBP_IDLE;
            // bytes past the last valid location are refused unwritten
            range_err_o <= state_reg == PMBP_IDLE && cmd_valid_i
                           && cmd_addr_i > `PMBP_ADDR_LAST;
            if (state_reg == PMBP_CHECK)
                read_data_o <= sync2_reg;
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    // strobes come from flops so no decode glitch reaches the part
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            program_strobe_n_o <= 1'b1;
            prom_address_bus_o <= `PMBP_ADDR_LOW;
            prom_data_bus_o <= 8'h00;
            prom_data_bus_oe_o <= 1'b0;
        end
        else
        begin
            ce_n_o <= (state_next == PMBP_IDLE);
            oe_n_o <= (sub_next != PMBP_SUB_VERIFY);
            program_strobe_n_o <= (sub_next != PMBP_SUB_WRITE);
            if (state_reg == PMBP_IDLE)
                prom_address_bus_o <= cmd_addr_i;
            prom_data_bus_o <= (state_reg == PMBP_IDLE) ? cmd_data_i
                               : data_reg;
            // data driven only in the write and overwrite setup, pulse and hold states, never while verifying
            prom_data_bus_oe_o <= state_next == PMBP_SETUP
                || state_next == PMBP_PULSE || state_next == PMBP_HOLD
                || state_next == PMBP_OV_SETUP
                || state_next == PMBP_OV_PULSE
                || state_next == PMBP_OV_HOLD;
        end
    end

    assign cmd_ready_o = (state_reg == PMBP_IDLE);
endmodule

// File: rtl/pmbp_params.svh
`ifndef PMBP_PARAMS_SVH
`define PMBP_PARAMS_SVH

// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define PMBP_CLK_PERIOD_NS 100
`define PMBP_SETUP_NS 2000
`define PMBP_HOLD_NS 2000
`define PMBP_OUT_DELAY_NS 150
`define PMBP_PULSE_NS 200000
`define PMBP_OVERWRITE_MIN_NS 190000
`define PMBP_OVERWRITE_MAX_NS 5250000
// least times round up, longest times round down
`define PMBP_CEIL_CYC(t) \
    (((t) + `PMBP_CLK_PERIOD_NS - 1) / `PMBP_CLK_PERIOD_NS)
`define PMBP_FLOOR_CYC(t) ((t) / `PMBP_CLK_PERIOD_NS)
`define PMBP_SETUP_CYC `PMBP_CEIL_CYC(`PMBP_SETUP_NS)
`define PMBP_HOLD_CYC `PMBP_CEIL_CYC(`PMBP_HOLD_NS)
// two extra cycles for the input synchroniser
`define PMBP_READ_CYC (`PMBP_CEIL_CYC(`PMBP_OUT_DELAY_NS) + 2)
`define PMBP_PULSE_CYC `PMBP_CEIL_CYC(`PMBP_PULSE_NS)
`define PMBP_OVERWRITE_MIN_CYC `PMBP_CEIL_CYC(`PMBP_OVERWRITE_MIN_NS)
`define PMBP_OVERWRITE_MAX_CYC `PMBP_FLOOR_CYC(`PMBP_OVERWRITE_MAX_NS)

// ----------------------------------------
// address map and data values
// ----------------------------------------
`define PMBP_ADDR_LOW 17'h0_0000
`define PMBP_ADDR_LAST 17'h0_EF7F
`define PMBP_ADDR_TOP 17'h1_FFFF
`define PMBP_BLANK_BYTE 8'hFF
`define PMBP_MAX_TRIES 25
`define PMBP_OVERWRITE_FACTOR 3

`endif

// File: rtl/pmbp_pkg.sv
package pmbp_pkg;

    typedef enum logic [3:0] {
        PMBP_IDLE = 4'b0000,
        PMBP_SETUP = 4'b0001,
        PMBP_PULSE = 4'b0010,
        PMBP_HOLD = 4'b0011,
        PMBP_OE_SETUP = 4'b0100,
        PMBP_READ = 4'b0101,
        PMBP_CHECK = 4'b0110,
        PMBP_OV_SETUP = 4'b0111,
        PMBP_OV_PULSE = 4'b1000,
        PMBP_OV_HOLD = 4'b1001
    } pmbp_state_t;

    typedef enum logic [1:0] {
        PMBP_SUB_INHIBIT = 2'b00,
        PMBP_SUB_WRITE = 2'b01,
        PMBP_SUB_VERIFY = 2'b10
    } pmbp_sub_t;

endpackage

// File: rtl/pmbp_tmr_if.sv
`timescale 1ns/1ns
interface pmbp_tmr_if #(
    parameter int WIDTH = 20
);
    logic load;
    logic [WIDTH-1:0] len;
    logic expired;

    modport ctl (
        output load,
        output len,
        input expired
    );
    modport tmr (
        input load,
        input len,
        output expired
    );
endinterface

// File: rtl/pmbp_timer.sv
`timescale 1ns/1ns
module pmbp_timer #(
    parameter int WIDTH = 20
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    pmbp_tmr_if.tmr tmr
);
    logic [WIDTH-1:0] cnt_reg;

    // a load of len keeps expired low for len-1 cycles after the load edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cnt_reg <= '0;
        else if (tmr.load)
            cnt_reg <= tmr.len - WIDTH'(1);
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - WIDTH'(1);
    end

    assign tmr.expired = (cnt_reg == '0);
endmodule

// File: verification/pmbp_eprom_model.sv
`timescale 1ns/1ns
module pmbp_eprom_model #(
    parameter int OUT_DLY_NS = 150
) (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic program_strobe_n_i,
    input wire logic [16:0] prom_address_bus_i,
    input wire logic [7:0] prom_data_bus_i,
    output logic [7:0] prom_data_bus_o
);
    // ----
    // cell array
    // ----
    logic [7:0] mem [0:131071];
    int pulse_cnt [0:131071];
    int need;
    logic [7:0] last_q;
    logic rd;
    initial
    begin
        need = 1;
        last_q = 8'h00;
        for (int i = 0; i < 131072; i++)
        begin
            mem[i] = 8'hFF;
            pulse_cnt[i] = 0;
        end
    end
    // a slow cell takes its value only after need pulses
    always @(posedge program_strobe_n_i)
    begin
        if (!ce_n_i && oe_n_i)
        begin
            pulse_cnt[prom_address_bus_i] += 1;
            if (pulse_cnt[prom_address_bus_i] >= need)
                mem[prom_address_bus_i] &= prom_data_bus_i;
        end
    end
    assign rd = !ce_n_i && !oe_n_i && program_strobe_n_i;
    always @(negedge rd)
        last_q = mem[prom_address_bus_i];
    // a floating bus shows the inverse, never a stale copy
    assign #(OUT_DLY_NS) prom_data_bus_o =
        rd ? mem[prom_address_bus_i] : ~last_q;
endmodule

// File: verification/pmbp_programmer_properties.sv
`timescale 1ns/1ns
`include "pmbp_params.svh"
module pmbp_programmer_properties #(
    parameter int MAX_TRIES = `PMBP_MAX_TRIES,
    parameter int OVERWRITE_MAX_CYC = `PMBP_OVERWRITE_MAX_CYC,
    parameter int PULSE_CYC = `PMBP_PULSE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid_i,
    input wire logic [16:0] cmd_addr_i,
    input wire logic cmd_ready_o,
    input wire logic done_o,
    input wire logic fail_o,
    input wire logic range_err_o,
    input wire logic ce_n_o,
    input wire logic oe_n_o,
    input wire logic program_strobe_n_o,
    input wire logic [16:0] prom_address_bus_o,
    input wire logic prom_data_bus_oe_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // ----
    // strobe width counter
    // ----
    int low_cnt;
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            low_cnt <= 0;
        else if (program_strobe_n_o)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    AST_NO_CONTENTION: assert property (
        !oe_n_o |-> !prom_data_bus_oe_o && program_strobe_n_o && !ce_n_o)
        else $error("data bus driven during verify");
    AST_WRITE_MODE: assert property (
        !program_strobe_n_o |-> prom_data_bus_oe_o && oe_n_o && !ce_n_o)
        else $error("strobe outside write sub-mode");
    AST_RANGE_REFUSED: assert property (
        cmd_valid_i && cmd_ready_o && cmd_addr_i > 17'h0_EF7F
        |=> range_err_o && ce_n_o)
        else $error("high address not refused");
    AST_ADDR_IN_RANGE: assert property (
        !program_strobe_n_o |-> prom_address_bus_o <= 17'h0_EF7F)
        else $error("pulse above valid range");
    AST_ADDR_STABLE: assert property (
        !ce_n_o && !$past(ce_n_o) |-> $stable(prom_address_bus_o))
        else $error("address moved within a byte");
    AST_PULSE_WIDTH: assert property (
        $rose(program_strobe_n_o) |-> low_cnt == PULSE_CYC ||
        (low_cnt >= `PMBP_OVERWRITE_MIN_CYC && low_cnt <= OVERWRITE_MAX_CYC))
        else $error("strobe width out of window");
    AST_READY_IDLE: assert property (
        cmd_ready_o |-> ce_n_o && oe_n_o && program_strobe_n_o)
        else $error("pins active while idle");
    AST_VERIFY_LEN: assert property (
        $fell(oe_n_o) |-> !oe_n_o [*4] ##1 oe_n_o)
        else $error("verify window not four cycles");
    AST_DATA_HOLD: assert property (
        $rose(program_strobe_n_o) |-> prom_data_bus_oe_o [*8])
        else $error("data released too early");
    AST_ONE_RESULT: assert property (
        done_o || fail_o |-> !(done_o && fail_o) ##1 !done_o && !fail_o)
        else $error("result pulse malformed");
    COV_DONE: cover property (done_o);
    COV_FAIL: cover property (fail_o);
    COV_RANGE: cover property (range_err_o);
    COV_VERIFY: cover property ($fell(oe_n_o));
endmodule
bind pmbp_programmer pmbp_programmer_properties #(
    .MAX_TRIES(MAX_TRIES), .OVERWRITE_MAX_CYC(OVERWRITE_MAX_CYC),
    .PULSE_CYC(PULSE_CYC)) i_props (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_addr_i(cmd_addr_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .fail_o(fail_o),
    .range_err_o(range_err_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
    .program_strobe_n_o(program_strobe_n_o),
    .prom_address_bus_o(prom_address_bus_o),
    .prom_data_bus_oe_o(prom_data_bus_oe_o));

// File: verification/pmbp_programmer_tb.sv
`timescale 1ns/1ns
module pmbp_programmer_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [16:0] cmd_addr = 17'h0_0000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, done, fail, range_err, ce_n, oe_n, pgm_n, bus_oe;
    logic [7:0] read_data, bus_out, bus_in, dev_q;
    logic [16:0] addr;
    int bad_count = 0;
    int cmp_count = 0;
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    pmbp_programmer #(.MAX_TRIES(3), .OVERWRITE_MAX_CYC(2000),
        .PULSE_CYC(10)) i_dut (
        .clk_sys_i(clk_sys), .reset_n_i(reset_n), .cmd_valid_i(cmd_valid),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .cmd_ready_o(cmd_ready), .done_o(done), .fail_o(fail),
        .range_err_o(range_err), .read_data_o(read_data), .ce_n_o(ce_n),
        .oe_n_o(oe_n), .program_strobe_n_o(pgm_n),
        .prom_address_bus_o(addr), .prom_data_bus_o(bus_out),
        .prom_data_bus_oe_o(bus_oe), .prom_data_bus_i(bus_in));
    pmbp_eprom_model i_dev (
        .ce_n_i(ce_n), .oe_n_i(oe_n), .program_strobe_n_i(pgm_n),
        .prom_address_bus_i(addr), .prom_data_bus_i(bus_in),
        .prom_data_bus_o(dev_q));
    assign bus_in = bus_oe ? bus_out : dev_q;
    // ----
    // shared tasks
    // ----
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // samples first, so a pulse at the current negedge is not lost
    task automatic wait_res(output logic [2:0] res);
        int n;
        n = 0;
        res = {range_err, fail, done};
        while (res === 3'b000 && n < 20000)
        begin
            @(negedge clk_sys);
            res = {range_err, fail, done};
            n++;
        end
        if (n >= 20000)
        begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic run_cmd(input logic [16:0] a, input logic [7:0] d,
                           output logic [2:0] res);
        @(negedge clk_sys);
        check(cmd_ready, 1'b1);
        cmd_valid = 1'b1;
        cmd_addr = a;
        cmd_data = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        wait_res(res);
    endtask
    task automatic prog(input logic [16:0] a, input logic [7:0] d,
                        input int need, input logic [2:0] er,
                        input int pulses, input logic [7:0] em);
        logic [2:0] res;
        i_dev.need = need;
        run_cmd(a, d, res);
        check(res, er);
        check(i_dev.mem[a], em);
        check(i_dev.pulse_cnt[a], pulses);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        check({ce_n, oe_n, pgm_n, bus_oe, cmd_ready}, 5'h1D);
    endtask
    task automatic t_program();
        prog(17'h0_0000, 8'h3C, 1, 3'b001, 2, 8'h3C);
        check(read_data, 8'h3C);
        prog(17'h0_EF7F, 8'h00, 1, 3'b001, 2, 8'h00);
    endtask
    task automatic t_blank();
        prog(17'h0_0100, 8'hFF, 1, 3'b001, 0, 8'hFF);
    endtask
    task automatic t_retry();
        prog(17'h0_0200, 8'h81, 2, 3'b001, 3, 8'h81);
        prog(17'h0_0300, 8'h00, 99, 3'b010, 3, 8'hFF);
    endtask
    task automatic t_range();
        prog(17'h0_EF80, 8'h12, 1, 3'b100, 0, 8'hFF);
        prog(17'h1_FFFF, 8'h34, 1, 3'b100, 0, 8'hFF);
    endtask
    task automatic t_back_to_back();
        logic [2:0] res;
        i_dev.need = 1;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_addr = 17'h0_0010;
        cmd_data = 8'h5A;
        @(negedge clk_sys);
        cmd_addr = 17'h0_0011;
        cmd_data = 8'hA5;
        wait_res(res);
        check(res, 3'b001);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        check(cmd_ready, 1'b0);
        wait_res(res);
        check(res, 3'b001);
        check(i_dev.mem[17'h0_0010], 8'h5A);
        check(i_dev.mem[17'h0_0011], 8'hA5);
        check(i_dev.mem[17'h0_0400], 8'hFF);
    endtask
    initial
    begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        t_reset();
        t_program();
        t_blank();
        t_retry();
        t_range();
        t_back_to_back();
        final_report();
    end
endmodule
